// >>> logic/wtu_pkg.sv
// package of the watchdog timeout unit: register map, fields, timing, carriers
// assumes a 10 MHz reference clock and an APB master with 32-bit data
package wtu_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int SECOND_NS     = 1_000_000_000;
    localparam int CYC_PER_SEC   = SECOND_NS / CLK_PERIOD_NS;
    localparam int SEC_PER_MIN   = 60;
    localparam int PULSE_NS      = 1000;                  // width of a pulse-mode timeout
    localparam int PULSE_CYC     = (PULSE_NS / CLK_PERIOD_NS < 1) ? 1
                                   : PULSE_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // register map: offsets are word indices, byte address is 4x
    // ------------------------------------------------------------------
    localparam int         ADDR_W        = 12;
    localparam logic [7:0] IDX_CONTROL   = 8'hf0;
    localparam logic [7:0] IDX_COUNT     = 8'hf1;
    localparam logic [7:0] IDX_STATE     = 8'hf2;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = {2'h0, IDX_CONTROL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_COUNT   = {2'h0, IDX_COUNT, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_STATE   = {2'h0, IDX_STATE, 2'h0};

    // ------------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------------
    localparam int         CTRL_LEVEL_BIT = 0;
    localparam int         CTRL_MINUTE_BIT = 3;
    localparam int         CTRL_W         = 4;            // bits 4..7 reserved, read zero
    localparam int         ST_TRIG_BIT    = 5;
    localparam int         ST_STATUS_BIT  = 4;
    localparam logic [7:0] ST_SPARE_MASK  = 8'hcf;        // unused bits that still store
    localparam logic [3:0] CTRL_RESET     = 4'h0;
    localparam logic [7:0] COUNT_RESET    = 8'h00;
    localparam logic [7:0] COUNT_OFF      = 8'h00;
    localparam logic [7:0] COUNT_LAST     = 8'h01;
    localparam logic [7:0] SPARE_RESET    = 8'h00;

    // ------------------------------------------------------------------
    // bus carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } wtu_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } wtu_apb_rsp_t;

endpackage

// >>> logic/wtu_tick_gen.sv
// free-running prescaler giving one-cycle second and minute ticks
// assumes the system clock and synchronous reset of the top module
`timescale 1ns/1ps
module wtu_tick_gen #(
    parameter int CYC_PER_SEC = 10_000_000,
    parameter int SEC_PER_MIN = 60
) (
    // clock and reset
    input  logic clk,
    input  logic rst,
    // tick enables
    output logic sec_tick,
    output logic min_tick
);
    localparam int CW = $clog2(CYC_PER_SEC);
    localparam int SW = $clog2(SEC_PER_MIN);

    typedef struct packed {
        logic [CW-1:0] cyc;
        logic [SW-1:0] sec;
        logic          s_tick;
        logic          m_tick;
    } wtu_tick_state_t;

    wtu_tick_state_t r, n;

    // ------------------------------------------------------------------
    // counters; never restarted by a reload, so the first unit is partial
    // ------------------------------------------------------------------
    always_comb begin
        n        = r;
        n.s_tick = 1'b0;
        n.m_tick = 1'b0;
        if (r.cyc == CW'(CYC_PER_SEC - 1)) begin
            n.cyc    = '0;
            n.s_tick = 1'b1;
            if (r.sec == SW'(SEC_PER_MIN - 1)) begin
                n.sec    = '0;
                n.m_tick = 1'b1;
            end else begin
                n.sec = r.sec + SW'(1);
            end
        end else begin
            n.cyc = r.cyc + CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign sec_tick = r.s_tick;
    assign min_tick = r.m_tick;

endmodule // wtu_tick_gen

// >>> logic/wtu_out_shaper.sv
// shapes timeout events into a pulse or a held level
// assumes fire and release are one-cycle strobes on the same clock
`timescale 1ns/1ps
module wtu_out_shaper #(
    parameter int PULSE_CYC = 10
) (
    // clock and reset
    input  logic clk,
    input  logic rst,
    // events
    input  logic fire,
    input  logic release_lvl,
    input  logic level_mode,
    // output
    output logic out
);
    localparam int PW = $clog2(PULSE_CYC + 1);

    typedef struct packed {
        logic [PW-1:0] left;
        logic          held;
        logic          out;
    } wtu_shape_state_t;

    wtu_shape_state_t r, n;

    // ------------------------------------------------------------------
    // a new event wins over a release in the same cycle
    // ------------------------------------------------------------------
    always_comb begin
        n = r;
        if (r.left != '0) begin
            n.left = r.left - PW'(1);
        end
        if (release_lvl) begin
            n.held = 1'b0;
        end
        if (fire) begin
            if (level_mode) begin
                n.held = 1'b1;
            end else begin
                n.left = PW'(PULSE_CYC);
            end
        end
        n.out = n.held | (n.left != '0);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign out = r.out;

endmodule // wtu_out_shaper

// >>> logic/wtu_top.sv
// watchdog timeout unit: APB register slave, down-counter, timeout output
// assumes a 10 MHz REF_CLK, synchronous RST, and an APB3 master
`timescale 1ns/1ps

module wtu_top #(
    parameter int CYC_PER_SEC_P = wtu_pkg::CYC_PER_SEC,
    parameter int SEC_PER_MIN_P = wtu_pkg::SEC_PER_MIN,
    parameter int PULSE_CYC_P   = wtu_pkg::PULSE_CYC
) (
    // clock and reset
    input  logic                  REF_CLK,
    input  logic                  RST,
    // register bus
    input  wtu_pkg::wtu_apb_req_t APB_REQ,
    output wtu_pkg::wtu_apb_rsp_t APB_RSP,
    // watchdog output
    output logic                  WDT_TIMEOUT
);
    import wtu_pkg::*;

    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [7:0]        cnt;
        logic              status;
        logic [7:0]        spare;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
    } wtu_top_state_t;

    wtu_top_state_t r, n;

    logic       sec_tick;
    logic       min_tick;
    logic       unit_tick;
    logic       acc;
    logic       done;
    logic       hit;
    logic       wr_ctrl;
    logic       wr_cnt;
    logic       wr_state;
    logic       reload;
    logic       expire;
    logic       trig;
    logic       fire;
    logic       release_lvl;
    logic [7:0] rd_byte;

    // ------------------------------------------------------------------
    // tick source and output shaper
    // ------------------------------------------------------------------
    wtu_tick_gen #(
        .CYC_PER_SEC (CYC_PER_SEC_P),
        .SEC_PER_MIN (SEC_PER_MIN_P)
    ) u_ticks (
        .clk      (REF_CLK),
        .rst      (RST),
        .sec_tick (sec_tick),
        .min_tick (min_tick)
    );

    wtu_out_shaper #(
        .PULSE_CYC (PULSE_CYC_P)
    ) u_shape (
        .clk         (REF_CLK),
        .rst         (RST),
        .fire        (fire),
        .release_lvl (release_lvl),
        .level_mode  (r.ctrl[CTRL_LEVEL_BIT]),
        .out         (WDT_TIMEOUT)
    );

    // ------------------------------------------------------------------
    // bus decode: one wait state, so read data comes from a flop
    // ------------------------------------------------------------------
    assign acc      = APB_REQ.psel & APB_REQ.penable;
    assign done     = acc & r.pready;
    assign wr_ctrl  = done & APB_REQ.pwrite & (APB_REQ.paddr == ADDR_CONTROL);
    assign wr_cnt   = done & APB_REQ.pwrite & (APB_REQ.paddr == ADDR_COUNT);
    assign wr_state = done & APB_REQ.pwrite & (APB_REQ.paddr == ADDR_STATE);

    // read mux; reserved control bits and the trigger bit read zero
    always_comb begin
        hit     = 1'b1;
        rd_byte = 8'h00;
        case (APB_REQ.paddr)
            ADDR_CONTROL: rd_byte = {{(8 - CTRL_W){1'b0}}, r.ctrl};
            ADDR_COUNT:   rd_byte = r.cnt;
            ADDR_STATE: begin
                rd_byte                = r.spare;
                rd_byte[ST_STATUS_BIT] = r.status;
            end
            default:      hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // watchdog events
    // ------------------------------------------------------------------
    // minute mode counts on minute ticks; the prescaler is not
    // restarted on load, which keeps it cheap at the cost of one unit
    assign unit_tick = r.ctrl[CTRL_MINUTE_BIT] ? min_tick : sec_tick;
    assign expire    = unit_tick & (r.cnt == COUNT_LAST);
    assign trig      = wr_state & APB_REQ.pwdata[ST_TRIG_BIT];
    assign reload    = wr_cnt & (APB_REQ.pwdata[7:0] != COUNT_OFF);
    assign fire      = expire | trig;
    assign release_lvl = reload | (wr_state & ~APB_REQ.pwdata[ST_STATUS_BIT]);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        n         = r;
        n.pready  = acc & ~r.pready;
        n.pslverr = acc & ~r.pready & ~hit;
        if (acc & ~r.pready) begin
            n.prdata = {24'h000000, rd_byte};
        end
        // countdown; zero holds, so the watchdog stays off
        if (unit_tick && (r.cnt != COUNT_OFF)) begin
            n.cnt = r.cnt - 8'h01;
        end
        if (wr_ctrl) begin
            n.ctrl = APB_REQ.pwdata[CTRL_W-1:0];
        end
        if (wr_cnt) begin
            n.cnt = APB_REQ.pwdata[7:0];
        end
        if (wr_state) begin
            n.spare  = APB_REQ.pwdata[7:0] & ST_SPARE_MASK;
            n.status = APB_REQ.pwdata[ST_STATUS_BIT];
        end
        if (reload) begin
            n.status = 1'b0;
        end
        // an event in the clearing cycle is kept: set wins
        if (fire) begin
            n.status = 1'b1;
        end
    end

    // reset leaves the count at zero, so the watchdog starts disabled
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            r         <= '0;
            r.ctrl    <= CTRL_RESET;
            r.cnt     <= COUNT_RESET;
            r.spare   <= SPARE_RESET;
        end else begin
            r <= n;
        end
    end

    // the bus answer comes straight from the state flops
    assign APB_RSP.prdata  = r.prdata;
    assign APB_RSP.pready  = r.pready;
    assign APB_RSP.pslverr = r.pslverr;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);

    a_level_bit_write: assert property (
        wr_ctrl |=> r.ctrl[CTRL_LEVEL_BIT] == $past(APB_REQ.pwdata[CTRL_LEVEL_BIT]))
        else $error("level select bit not stored");

    a_unit_bit_select: assert property (
        (r.ctrl[CTRL_MINUTE_BIT] && sec_tick && !min_tick && !wr_cnt) |=> $stable(r.cnt))
        else $error("minute mode counted on a second tick");

    a_load_nonzero: assert property (
        reload |=> (r.cnt == $past(APB_REQ.pwdata[7:0])) && !r.status || $past(fire))
        else $error("non-zero write did not load the counter");

    a_reload_resumes: assert property (
        (reload && !fire) ##1 (unit_tick && !wr_cnt) |=> r.cnt == $past(r.cnt) - 8'h01)
        else $error("countdown did not resume after reload");

    a_read_live_count: assert property (
        (acc && !r.pready && !APB_REQ.pwrite && APB_REQ.paddr == ADDR_COUNT)
        |=> APB_RSP.pready && APB_RSP.prdata == {24'h000000, $past(r.cnt)})
        else $error("counter read did not return live count");

    a_zero_is_off: assert property (
        (r.cnt == COUNT_OFF && !wr_cnt) |=> (r.cnt == COUNT_OFF) && !$past(expire))
        else $error("disabled counter moved or expired");

    a_hold_between_ticks: assert property (
        (!unit_tick && !wr_cnt) |=> $stable(r.cnt))
        else $error("count changed without a unit tick");

    a_trigger_event: assert property (
        trig |=> r.status && WDT_TIMEOUT && APB_RSP.prdata[ST_TRIG_BIT] == 1'b0)
        else $error("trigger did not force a timeout");

    a_expire_status: assert property (
        expire |=> r.status && (r.cnt == COUNT_OFF || $past(wr_cnt)))
        else $error("expiry did not set status");

    a_level_holds: assert property (
        (WDT_TIMEOUT && r.ctrl[CTRL_LEVEL_BIT] && !release_lvl && !wr_ctrl)
        |=> WDT_TIMEOUT[*1])
        else $error("level timeout dropped without release");

    // ------------------------------------------------------------------
    // checks of the register path, the events and the prescaler
    // ------------------------------------------------------------------
    // read data is captured in the first access cycle, so the value that
    // the master takes is one cycle old; the read checks compare against
    // that cycle and not against the state at the taking edge, which a
    // tick may already have moved

    a_minute_bit_write: assert property (
        wr_ctrl |=> r.ctrl[CTRL_MINUTE_BIT] == $past(APB_REQ.pwdata[CTRL_MINUTE_BIT]))
        else $error("unit select bit not stored");

    a_control_readback: assert property (
        (acc && !r.pready && !APB_REQ.pwrite && APB_REQ.paddr == ADDR_CONTROL)
        |=> APB_RSP.prdata[CTRL_LEVEL_BIT] == $past(r.ctrl[CTRL_LEVEL_BIT]))
        else $error("level select bit did not read back");

    a_second_mode_count: assert property (
        (!r.ctrl[CTRL_MINUTE_BIT] && sec_tick && r.cnt != COUNT_OFF && !wr_cnt)
        |=> r.cnt == $past(r.cnt) - 8'h01)
        else $error("second mode did not count on a second tick");

    a_one_expires: assert property (
        (unit_tick && r.cnt == COUNT_LAST && !wr_cnt) |=> r.cnt == COUNT_OFF && r.status)
        else $error("count of one did not expire on its tick");

    a_zero_write_off: assert property (
        (wr_cnt && APB_REQ.pwdata[7:0] == COUNT_OFF) |=> r.cnt == COUNT_OFF)
        else $error("zero write did not disable the counter");

    a_reload_clears: assert property (
        (reload && !fire) |=> !r.status)
        else $error("reload did not restart the watchdog");

    a_status_write: assert property (
        (wr_state && !fire) |=> r.status == $past(APB_REQ.pwdata[ST_STATUS_BIT]))
        else $error("status bit not written");

    a_status_until_clear: assert property (
        (r.status && !wr_state && !reload) |=> r.status)
        else $error("status bit dropped by itself");

    a_status_readback: assert property (
        (acc && !r.pready && !APB_REQ.pwrite && APB_REQ.paddr == ADDR_STATE)
        |=> APB_RSP.prdata[ST_STATUS_BIT] == $past(r.status))
        else $error("status bit did not read back");

    a_trigger_reads_zero: assert property (
        (acc && !r.pready && !APB_REQ.pwrite && APB_REQ.paddr == ADDR_STATE)
        |=> !APB_RSP.prdata[ST_TRIG_BIT])
        else $error("trigger bit did not read zero");

    a_zero_no_event: assert property (
        (wr_state && !APB_REQ.pwdata[ST_TRIG_BIT] && !APB_REQ.pwdata[ST_STATUS_BIT] && !expire)
        |=> !r.status)
        else $error("writing zero to the trigger raised an event");

    a_fire_raises_out: assert property (
        fire |=> WDT_TIMEOUT)
        else $error("timeout event did not raise the output");

    a_trigger_level_hold: assert property (
        (trig && r.ctrl[CTRL_LEVEL_BIT])
        |=> WDT_TIMEOUT ##1 (WDT_TIMEOUT || $past(release_lvl)))
        else $error("level timeout did not hold after a trigger");

    a_reset_clears: assert property (
        $past(RST) |-> r.ctrl == CTRL_RESET && r.cnt == COUNT_RESET
        && !r.status && !WDT_TIMEOUT)
        else $error("reset left the watchdog armed");

    a_minute_on_second: assert property (
        min_tick |-> sec_tick)
        else $error("minute tick off the second grid");

    a_tick_one_cycle: assert property (
        sec_tick |=> !sec_tick)
        else $error("second tick longer than a cycle");

    a_ready_one_cycle: assert property (
        APB_RSP.pready |=> !APB_RSP.pready)
        else $error("ready held past one cycle");

    a_idle_no_ready: assert property (
        !acc |=> !APB_RSP.pready)
        else $error("ready raised without an access");

endmodule // wtu_top

// >>> verification/watchdog_timeout_unit_tb.sv
// self-checking testbench of the watchdog timeout unit
// assumes wtu_pkg and wtu_top are compiled first; the bench is the only APB master
`timescale 1ns/1ps
module watchdog_timeout_unit_tb;
    import wtu_pkg::*;

    // ------------------------------------------------------------------
    // shortened counts: a second is 20 cycles, a minute 60, a pulse 3
    // ------------------------------------------------------------------
    localparam int          CPS       = 20;
    localparam int          SPM       = 3;
    localparam int          PLS       = 3;
    localparam logic [11:0] ADDR_NONE = 12'h3cc;    // first word past the map

    logic         ref_clk;
    logic         rst;
    wtu_apb_req_t req;
    wtu_apb_rsp_t rsp;
    logic         wdt_out;
    int           hi_cycles;
    int           hi_base;
    logic [31:0]  rdv;
    logic         err;
    time          t0;
    int           n;
    int           failures;
    int           tests_run;

    wtu_top #(.CYC_PER_SEC_P(CPS), .SEC_PER_MIN_P(SPM), .PULSE_CYC_P(PLS)) dut (
        .REF_CLK     (ref_clk),
        .RST         (rst),
        .APB_REQ     (req),
        .APB_RSP     (rsp),
        .WDT_TIMEOUT (wdt_out)
    );

    // 10 MHz clock
    always #50 ref_clk = ~ref_clk;

    // running count of high cycles, so short pulses between checks are not missed
    always @(posedge ref_clk) begin
        if (rst) begin
            hi_cycles <= 0;
        end else if (wdt_out === 1'b1) begin
            hi_cycles <= hi_cycles + 1;
        end
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // one APB transfer; the request stands until pready is seen high at a
    // rising edge, and data and error are taken and the bus released there
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge ref_clk);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= w;
        req.paddr   <= a;
        req.pwdata  <= {24'h0, d};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
        end while (rsp.pready !== 1'b1 && k < 16);
        if (rsp.pready !== 1'b1) begin
            failures++;
            summarize();
        end
        rdv = rsp.prdata;
        err = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask

    // bounded wait for the timeout output to rise
    task automatic wait_hi(input int bound);
        n = 0;
        while (wdt_out !== 1'b1 && n < bound) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= bound) begin
            failures++;
            summarize();
        end
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        check({31'h0, wdt_out}, 32'h0);
        apb(1'b0, ADDR_CONTROL, 8'h00); check(rdv, 32'h0);
        apb(1'b0, ADDR_COUNT, 8'h00);   check(rdv, 32'h0);
        apb(1'b0, ADDR_STATE, 8'h00);   check(rdv, 32'h0);
        apb(1'b0, ADDR_NONE, 8'h00);    check(rdv, 32'h0);
        check({31'h0, err}, 32'h1);
        $display("test reset done");
    endtask

    task automatic t_control();
        apb(1'b1, ADDR_CONTROL, 8'hff);
        apb(1'b0, ADDR_CONTROL, 8'h00); check(rdv, 32'h0f);
        apb(1'b1, ADDR_CONTROL, 8'h00);
        apb(1'b0, ADDR_CONTROL, 8'h00); check(rdv, 32'h00);
        $display("test control done");
    endtask

    // pulse mode, seconds, count of two
    task automatic t_pulse();
        apb(1'b1, ADDR_COUNT, 8'h02);
        t0 = $time;
        wait_hi(60);
        n = int'(($time - t0) / 100);
        check({31'h0, n >= 21 && n <= 42}, 32'h1);
        n = 0;
        while (wdt_out === 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        check(n, PLS);
        apb(1'b0, ADDR_STATE, 8'h00); check(rdv, 32'h10);
        apb(1'b0, ADDR_COUNT, 8'h00); check(rdv, 32'h00);
        $display("test pulse done");
    endtask

    // level mode, serviced in time, then left to expire and cleared
    task automatic t_reload();
        apb(1'b1, ADDR_CONTROL, 8'h01);
        hi_base = hi_cycles;
        repeat (8) begin
            apb(1'b1, ADDR_COUNT, 8'h02);
            repeat (10) @(posedge ref_clk);
        end
        check(hi_cycles - hi_base, 32'h0);
        apb(1'b0, ADDR_STATE, 8'h00); check(rdv, 32'h00);
        wait_hi(60);
        repeat (30) @(negedge ref_clk);
        check({31'h0, wdt_out}, 32'h1);
        apb(1'b1, ADDR_STATE, 8'h00);
        repeat (2) @(negedge ref_clk);
        check({31'h0, wdt_out}, 32'h0);
        $display("test reload done");
    endtask

    // forced event, release by reload, then disable by zero
    task automatic t_trigger();
        apb(1'b1, ADDR_STATE, 8'h20);
        repeat (2) @(negedge ref_clk);
        check({31'h0, wdt_out}, 32'h1);
        apb(1'b0, ADDR_STATE, 8'h00); check(rdv, 32'h10);
        apb(1'b1, ADDR_COUNT, 8'h05);
        repeat (2) @(negedge ref_clk);
        check({31'h0, wdt_out}, 32'h0);
        apb(1'b0, ADDR_STATE, 8'h00); check(rdv, 32'h00);
        apb(1'b1, ADDR_COUNT, 8'h00);
        hi_base = hi_cycles;
        apb(1'b1, ADDR_STATE, 8'h00);
        repeat (150) @(posedge ref_clk);
        check(hi_cycles - hi_base, 32'h0);
        $display("test trigger done");
    endtask

    // minute units: three counts must outlast what seconds would give
    task automatic t_minute();
        apb(1'b1, ADDR_CONTROL, 8'h08);
        apb(1'b1, ADDR_COUNT, 8'h03);
        t0 = $time;
        hi_base = hi_cycles;
        repeat (100) @(posedge ref_clk);
        check(hi_cycles - hi_base, 32'h0);
        apb(1'b0, ADDR_COUNT, 8'h00);
        check({31'h0, rdv == 32'h1 || rdv == 32'h2}, 32'h1);
        wait_hi(100);
        n = int'(($time - t0) / 100);
        check({31'h0, n >= 121 && n <= 182}, 32'h1);
        $display("test minute done");
    endtask

    // reset in mid-run: a loaded, fired watchdog must come back disabled
    task automatic t_restart();
        apb(1'b1, ADDR_CONTROL, 8'h09);
        apb(1'b1, ADDR_COUNT, 8'h05);
        apb(1'b1, ADDR_STATE, 8'h20);
        @(posedge ref_clk);
        check({31'h0, wdt_out}, 32'h1);
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        $display("test restart done");
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        ref_clk   = 1'b0;
        rst       = 1'b1;
        req       = '0;
        failures  = 0;
        tests_run = 0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_control();
        t_pulse();
        t_reload();
        t_trigger();
        t_minute();
        t_restart();
        summarize();
    end

endmodule // watchdog_timeout_unit_tb
